// file: rtl/fdcr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef FDCR_REGS_SVH
`define FDCR_REGS_SVH
`define FDCR_ADDR_STATUS_B    10'h3f1
`define FDCR_ADDR_DRIVE_CTRL  10'h3f2
`define FDCR_ADDR_TAPE        10'h3f3
`define FDCR_ADDR_DIGITAL_IN  10'h3f7
`define FDCR_DOC_RESET        8'h00
`define FDCR_TAPE_RESET       2'h0
`define FDCR_DOC_DRIVE_LO     0
`define FDCR_DOC_SOFT_RST     2
`define FDCR_DOC_DMA_EN       3
`define FDCR_DOC_MOTOR_LO     4
`define FDCR_SRB_RSVD         2'h3
`define FDCR_SOFT_RST_MIN_NS  100
`define FDCR_CLK_PERIOD_NS    100
`define FDCR_SOFT_RST_CYCLES  ((`FDCR_SOFT_RST_MIN_NS + `FDCR_CLK_PERIOD_NS - 1) / `FDCR_CLK_PERIOD_NS)
`endif

// file: rtl/fdcr_pkg.sv
// types shared by the drive control register block
package fdcr_pkg;
   typedef enum logic [1:0] {FDCR_MODE_AT, FDCR_MODE_ENH, FDCR_MODE_LEGACY} fdcr_mode_t;
   typedef struct packed
   {
      logic [3:0] motor_bit;
      logic       dma_irq_pin_enable;
      logic       soft_reset_bar;
      logic [1:0] drive_num;
   } fdcr_doc_t;
   typedef struct packed
   {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       rd;
      logic       wr;
   } fdcr_host_t;
endpackage : fdcr_pkg

// file: rtl/fdcr_drive_ctrl.sv
// floppy drive control, tape select and disk status b registers
`timescale 1ns/100ps
`include "fdcr_regs.svh"

// Behaviour
// - enhanced mode status bits 1:0 show motor 1 and 0 outputs, active high.
// - enhanced mode status bit 2 shows current write gate level.
// - enhanced bits 3 and 4 toggle on inactive edges of read and write data.
// - enhanced bit 5 mirrors drive number bit 0; soft reset keeps it.
// - enhanced status bits 7:6 always read one.
// - legacy bits 1:0 show drive select 3 and 2, active low.
// - legacy bits 7:5 show second drive, select 1, select 0, active low.
// - legacy bit 2 latches write gate going active, clears on input register read.
// - legacy bit 3 latches read data inactive edge, clears on input register read.
// - legacy bit 4 latches write data inactive edge regardless of write gate.
// - control register: drive number, soft reset bar, dma enable, four motors; reset zero.
// - control register writable anytime; soft reset leaves it unchanged.
// - zero in bit 2 holds controller reset until one written; others untouched.
// - one write cycle of reset bit is a complete soft reset.
// - basic and legacy modes: dma enable gates dma and interrupt pins.
// - enhanced mode: dma and interrupt pins always enabled, even in reset.
// - motor bits 7:4 drive motor outputs 3:0, one means active.
// - tape register keeps bits 1:0 through soft reset; bits 7:2 float on read.
// - tape field 00 none, 01..11 drives 1..3.
// - select N low only for drive number N with its motor bit set.
// - swap exchanges selects 0 and 1, motor 0 from bit 5, motor 1 from bit 4.
// - basic mode read of status b address leaves data bus undriven.
module fdcr_drive_ctrl
   import fdcr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire fdcr_mode_t  cfg_mode,
   input  wire logic        cfg_swap,
   input  wire fdcr_host_t  host,
   output logic      [7:0]  rdata,
   output logic      [7:0]  rdata_oe,
   input  wire logic        read_data_bar,
   input  wire logic        write_data_bar,
   input  wire logic        write_gate_out,
   input  wire logic        second_drive_present_bar,
   input  wire logic        core_dma_request,
   input  wire logic        core_floppy_irq,
   input  wire logic        dma_ack_bar,
   input  wire logic        terminal_count,
   output logic      [3:0]  drive_select_out_bar,
   output logic      [3:0]  motor_on_out_bar,
   output logic             dma_request,
   output logic             dma_request_oe,
   output logic             floppy_irq,
   output logic             floppy_irq_oe,
   output logic             dma_ack_bar_gated,
   output logic             terminal_count_gated,
   output logic             core_reset
);

   ////////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers and edge detection
   logic [2:0] rd_sync;
   logic [2:0] wd_sync;
   logic [2:0] wg_sync;
   logic [2:0] second_drive_present_sync;
   logic [2:0] ack_sync;
   logic [2:0] tc_sync;
   logic       rd_lvl;
   logic       wd_lvl;
   logic       wg_lvl;
   logic       second_drive_present_lvl;
   logic       ack_lvl;
   logic       tc_lvl;

   // a change counts once stages two and three agree
   function automatic logic filt(input logic [2:0] s, input logic prev);
      filt = (s[1] == s[2]) ? s[2] : prev;
   endfunction : filt

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_sync   <= 3'h7;
         wd_sync   <= 3'h7;
         wg_sync   <= 3'h0;
         second_drive_present_sync <= 3'h7;
         ack_sync  <= 3'h7;
         tc_sync   <= 3'h0;
      end
      else
      begin
         rd_sync   <= {rd_sync[1:0], read_data_bar};
         wd_sync   <= {wd_sync[1:0], write_data_bar};
         wg_sync   <= {wg_sync[1:0], write_gate_out};
         second_drive_present_sync <= {second_drive_present_sync[1:0], second_drive_present_bar};
         ack_sync  <= {ack_sync[1:0], dma_ack_bar};
         tc_sync   <= {tc_sync[1:0], terminal_count};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_lvl   <= 1'b1;
         wd_lvl   <= 1'b1;
         wg_lvl   <= 1'b0;
         second_drive_present_lvl <= 1'b1;
         ack_lvl  <= 1'b1;
         tc_lvl   <= 1'b0;
      end
      else
      begin
         rd_lvl   <= filt(rd_sync, rd_lvl);
         wd_lvl   <= filt(wd_sync, wd_lvl);
         wg_lvl   <= filt(wg_sync, wg_lvl);
         second_drive_present_lvl <= filt(second_drive_present_sync, second_drive_present_lvl);
         ack_lvl  <= filt(ack_sync, ack_lvl);
         tc_lvl   <= filt(tc_sync, tc_lvl);
      end
   end

   // data lines are active low: inactive edge is a rise
   logic rd_inactive_edge;
   logic wd_inactive_edge;
   logic wg_active_edge;
   assign rd_inactive_edge = !rd_lvl && filt(rd_sync, rd_lvl);
   assign wd_inactive_edge = !wd_lvl && filt(wd_sync, wd_lvl);
   assign wg_active_edge   = !wg_lvl && filt(wg_sync, wg_lvl);

   ////////////////////////////////////////////////////////////////////////////////
   // host decode
   logic wr_doc;
   logic wr_tape;
   logic rd_dir;
   logic rd_sb;
   logic rd_doc;
   logic rd_tape;

   // one address compare shared by every strobe decode
   function automatic logic hit(input fdcr_host_t h, input logic [9:0] a);
      hit = (h.addr == a);
   endfunction : hit

   assign wr_doc  = host.wr && hit(host, `FDCR_ADDR_DRIVE_CTRL);
   assign wr_tape = host.wr && hit(host, `FDCR_ADDR_TAPE);
   assign rd_dir  = host.rd && hit(host, `FDCR_ADDR_DIGITAL_IN);
   assign rd_sb   = host.rd && hit(host, `FDCR_ADDR_STATUS_B);
   assign rd_doc  = host.rd && hit(host, `FDCR_ADDR_DRIVE_CTRL);
   assign rd_tape = host.rd && hit(host, `FDCR_ADDR_TAPE);

   ////////////////////////////////////////////////////////////////////////////////
   // control and tape registers: hardware reset only
   fdcr_doc_t  doc;
   logic [1:0] tape_select;

   always_ff @(posedge clk)
   begin
      if (rst)
         doc <= `FDCR_DOC_RESET;
      else if (wr_doc)
         doc <= host.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         tape_select <= `FDCR_TAPE_RESET;
      else if (wr_tape)
         tape_select <= host.wdata[1:0];
   end

   // reset held as long as the bit is zero; one write cycle already meets the minimum
   always_ff @(posedge clk)
   begin
      if (rst)
         core_reset <= 1'b1;
      else
         core_reset <= wr_doc ? !host.wdata[`FDCR_DOC_SOFT_RST] : !doc.soft_reset_bar;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status b toggles and latches; set wins over the clearing read
   logic rd_toggle;
   logic wd_toggle;
   logic wg_latch;
   logic rd_latch;
   logic wd_latch;

   always_ff @(posedge clk)
   begin
      if (rst)
         rd_toggle <= 1'b0;
      else
         rd_toggle <= rd_toggle ^ rd_inactive_edge;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         wd_toggle <= 1'b0;
      else
         wd_toggle <= wd_toggle ^ wd_inactive_edge;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         wg_latch <= 1'b0;
      else
         wg_latch <= wg_active_edge || (wg_latch && !rd_dir);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         rd_latch <= 1'b0;
      else
         rd_latch <= rd_inactive_edge || (rd_latch && !rd_dir);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         wd_latch <= 1'b0;
      else
         wd_latch <= wd_inactive_edge || (wd_latch && !rd_dir);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // drive select and motor decode
   function automatic logic [7:0] decode(input fdcr_doc_t d, input logic swap);
      logic [3:0] sel;
      logic [3:0] mot;
      sel = 4'hf;
      mot = ~d.motor_bit;
      if (d.motor_bit[d.drive_num])
         sel[d.drive_num] = 1'b0;
      if (swap)
      begin
         sel = {sel[3:2], sel[0], sel[1]};
         mot = {mot[3:2], mot[0], mot[1]};
      end
      decode = {sel, mot};
   endfunction : decode

   logic [7:0] next_drive;
   assign next_drive = decode(doc, cfg_swap);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         drive_select_out_bar <= 4'hf;
         motor_on_out_bar     <= 4'hf;
      end
      else
      begin
         drive_select_out_bar <= next_drive[7:4];
         motor_on_out_bar     <= next_drive[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // dma and interrupt pin gating
   logic pins_on;
   assign pins_on = (cfg_mode == FDCR_MODE_ENH) || doc.dma_irq_pin_enable;

   // enhanced mode keeps the pins live even while reset is held
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dma_request_oe <= (cfg_mode == FDCR_MODE_ENH);
         floppy_irq_oe  <= (cfg_mode == FDCR_MODE_ENH);
      end
      else
      begin
         dma_request_oe <= pins_on;
         floppy_irq_oe  <= pins_on;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dma_request          <= 1'b0;
         floppy_irq           <= 1'b0;
         dma_ack_bar_gated    <= 1'b1;
         terminal_count_gated <= 1'b0;
      end
      else
      begin
         dma_request          <= core_dma_request;
         floppy_irq           <= core_floppy_irq;
         dma_ack_bar_gated    <= pins_on ? ack_lvl : 1'b1;
         terminal_count_gated <= pins_on && tc_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data path
   logic [7:0] status_b;
   always_comb
   begin
      if (cfg_mode == FDCR_MODE_ENH)
         status_b = {`FDCR_SRB_RSVD, doc.drive_num[0], wd_toggle, rd_toggle,
                     wg_lvl, ~motor_on_out_bar[1:0]};
      else
         status_b = {second_drive_present_lvl, drive_select_out_bar[1:0], wd_latch, rd_latch,
                     wg_latch, drive_select_out_bar[3:2]};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata    <= 8'h00;
         rdata_oe <= 8'h00;
      end
      else if (rd_sb && cfg_mode != FDCR_MODE_AT)
      begin
         rdata    <= status_b;
         rdata_oe <= 8'hff;
      end
      else if (rd_doc)
      begin
         rdata    <= doc;
         rdata_oe <= 8'hff;
      end
      else if (rd_tape)
      begin
         rdata    <= {6'h00, tape_select};
         rdata_oe <= 8'h03;
      end
      else
      begin
         rdata    <= 8'h00;
         rdata_oe <= 8'h00;
      end
   end

endmodule : fdcr_drive_ctrl

// file: bench/fdcr_drive_ctrl_asserts.sv
// port assertions for the drive control register block
`timescale 1ns/100ps
module fdcr_drive_ctrl_asserts
   import fdcr_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire fdcr_mode_t cfg_mode,
   input wire logic       cfg_swap,
   input wire fdcr_host_t host,
   input wire logic [7:0] rdata,
   input wire logic [7:0] rdata_oe,
   input wire logic [3:0] drive_select_out_bar,
   input wire logic [3:0] motor_on_out_bar,
   input wire logic       dma_request_oe,
   input wire logic       floppy_irq_oe,
   input wire logic       dma_ack_bar_gated,
   input wire logic       terminal_count_gated,
   input wire logic       dma_request,
   input wire logic       floppy_irq,
   input wire logic       core_dma_request,
   input wire logic       core_floppy_irq,
   input wire logic       core_reset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic       wr_doc;
   logic       rd_sb;
   logic [3:0] m;
   logic [3:0] sel;
   logic [3:0] exp_sel;
   logic [3:0] exp_mtr;
   assign wr_doc  = host.wr && host.addr == 10'h3f2;
   assign rd_sb   = host.rd && host.addr == 10'h3f1;
   assign m       = host.wdata[7:4];
   // a select only drops when its motor bit is on
   assign sel     = m[host.wdata[1:0]] ? ~(4'h1 << host.wdata[1:0]) : 4'hf;
   assign exp_sel = cfg_swap ? {sel[3:2], sel[0], sel[1]} : sel;
   assign exp_mtr = cfg_swap ? ~{m[3:2], m[0], m[1]} : ~m;
   ////////////////////////////////////////
   AST_MTR: assert property (wr_doc |-> ##2 motor_on_out_bar == $past(exp_mtr, 2))
      else $error("motor outputs wrong");
   AST_SEL: assert property (wr_doc |-> ##2 drive_select_out_bar == $past(exp_sel, 2))
      else $error("drive selects wrong");
   AST_CORE_RST: assert property (wr_doc |=> core_reset == !$past(host.wdata[2]))
      else $error("core reset wrong");
   AST_DOC_OE: assert property (host.rd && host.addr == 10'h3f2 |=> rdata_oe == 8'hff)
      else $error("control read not driven");
   AST_TAPE_OE: assert property (host.rd && host.addr == 10'h3f3 |=> rdata_oe == 8'h03)
      else $error("tape read drive wrong");
   AST_AT_FLOAT: assert property (rd_sb && cfg_mode == FDCR_MODE_AT |=> rdata_oe == 8'h00)
      else $error("status driven in basic mode");
   AST_ENH_RSVD: assert property (rd_sb && cfg_mode == FDCR_MODE_ENH |=> rdata[7:6] == 2'h3)
      else $error("reserved status bits wrong");
   AST_ENH_PINS: assert property ((cfg_mode == FDCR_MODE_ENH) [*3] |-> dma_request_oe && floppy_irq_oe)
      else $error("pins not enabled");
   AST_GATE: assert property (wr_doc && cfg_mode != FDCR_MODE_ENH && !host.wdata[3] |-> ##2
      !dma_request_oe && !floppy_irq_oe && dma_ack_bar_gated)
      else $error("dma pins not gated");
   AST_DRQ: assert property (1'b1 |=> dma_request == $past(core_dma_request) &&
      floppy_irq == $past(core_floppy_irq))
      else $error("request or interrupt level wrong");
   AST_TC_GATE: assert property (!dma_request_oe |->
      !terminal_count_gated && dma_ack_bar_gated)
      else $error("ack or count not ignored");
   AST_RST_PINS: assert property (disable iff (1'b0)
      rst && cfg_mode == FDCR_MODE_ENH |=> dma_request_oe && floppy_irq_oe)
      else $error("pins dropped in reset");
   cover property (wr_doc && cfg_swap);
   cover property (rd_sb && cfg_mode == FDCR_MODE_LEGACY);
   cover property ($rose(core_reset));
endmodule : fdcr_drive_ctrl_asserts

// file: bench/fdcr_drive_model.sv
// drive side model: data pulses and drive present pin
`timescale 1ns/100ps
module fdcr_drive_model
#(
   parameter logic PRESENT_BAR = 1'b0
)
(
   input  wire logic clk,
   output logic      read_data_bar,
   output logic      write_data_bar,
   output logic      second_drive_present_bar
);
   initial
   begin
      read_data_bar            = 1'b1;
      write_data_bar           = 1'b1;
      second_drive_present_bar = PRESENT_BAR;
   end
   // low for three cycles so the input synchroniser cannot miss it
   task automatic pulse(input logic wdat);
      @(posedge clk);
      #1;
      read_data_bar  = wdat;
      write_data_bar = !wdat;
      repeat (3) @(posedge clk);
      #1;
      read_data_bar  = 1'b1;
      write_data_bar = 1'b1;
   endtask : pulse
endmodule : fdcr_drive_model

// file: bench/fdcr_drive_ctrl_test.sv
// self-checking bench for the drive control register block
`timescale 1ns/100ps
module fdcr_drive_ctrl_test;
   import fdcr_pkg::*;
   logic        clk, rst, cfg_swap, write_gate_out, core_dma_request, core_floppy_irq;
   logic        dma_ack_bar, terminal_count, read_data_bar, write_data_bar;
   logic        second_drive_present_bar, dma_request_oe, floppy_irq_oe;
   logic        dma_ack_bar_gated, core_reset, noted, noted_d;
   logic        dma_request, floppy_irq, terminal_count_gated;
   fdcr_mode_t  cfg_mode;
   fdcr_host_t  host;
   logic [7:0]  rdata, rdata_oe, v;
   logic [3:0]  drive_select_out_bar, motor_on_out_bar;
   logic [15:0] notes[$];
   logic [7:0]  act[4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
   int          fails, samples_checked, cycles;
   fdcr_drive_ctrl u_fdcr_drive_ctrl (.clk, .rst, .cfg_mode, .cfg_swap, .host, .rdata,
      .rdata_oe, .read_data_bar, .write_data_bar, .write_gate_out, .second_drive_present_bar,
      .core_dma_request, .core_floppy_irq, .dma_ack_bar, .terminal_count, .drive_select_out_bar,
      .motor_on_out_bar, .dma_request, .dma_request_oe, .floppy_irq, .floppy_irq_oe,
      .dma_ack_bar_gated, .terminal_count_gated, .core_reset);
   fdcr_drive_model u_fdcr_drive_model (.clk, .read_data_bar, .write_data_bar,
      .second_drive_present_bar);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   task automatic op(input logic r, w, input logic [9:0] a, input logic [7:0] d, input logic n);
      host  = {a, d, r, w};
      noted = n;
      @(posedge clk);
      #1;
   endtask : op
   task automatic bus_rd(input logic [9:0] a, input logic [7:0] d, o);
      notes.push_back({d & o, o});
      op(1'b1, 1'b0, a, 8'h00, 1'b1);
   endtask : bus_rd
   task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
      op(1'b0, 1'b1, a, d, 1'b0);
   endtask : bus_wr
   task automatic idle(input int n);
      repeat (n) op(1'b0, 1'b0, 10'h000, 8'h00, 1'b0);
   endtask : idle
   task automatic do_reset(input fdcr_mode_t md, input logic s);
      cfg_mode = md;
      cfg_swap = s;
      rst      = 1'b1;
      idle(2);
      rst      = 1'b0;
   endtask : do_reset
   task automatic chk(input logic [15:0] e);
      samples_checked++;
      if ({rdata & e[7:0], rdata_oe} !== e)
      begin
         fails++;
         $display("ERROR read data/oe expected %h seen %h", e, {rdata, rdata_oe});
      end
   endtask : chk
   task automatic chk_pin(input string nm, input logic e, input logic s);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR %s expected %b seen %b", nm, e, s);
      end
   endtask : chk_pin
   // read data stands from the edge that takes the request to the next; look mid-cycle
   always @(negedge clk)
   begin
      if (noted_d)
         chk(notes.pop_front());
   end
   always @(posedge clk)
   begin
      noted_d <= noted;
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         close_out();
      end
   end
   initial
   begin
      {host, noted, noted_d, cfg_swap, write_gate_out} = '0;
      {core_dma_request, core_floppy_irq, terminal_count, rst, dma_ack_bar} = 5'h3;
      cfg_mode = FDCR_MODE_ENH;
      {fails, samples_checked, cycles} = '0;
      v = 8'($urandom(80512));
      @(posedge clk);
      #1;
      do_reset(FDCR_MODE_ENH, 1'b0);
      bus_rd(10'h3f2, 8'h00, 8'hff);
      bus_rd(10'h3f1, 8'hc0, 8'hff);
      for (int i = 0; i < 12; i++)
      begin
         v = (i < 4) ? act[i] : 8'($urandom);
         {core_dma_request, core_floppy_irq, dma_ack_bar, terminal_count} = 4'($urandom);
         bus_wr(10'h3f2, v);
         idle(3);
         bus_rd(10'h3f2, v, 8'hff);
         bus_rd(10'h3f1, {2'h3, v[0], 3'h0, v[5:4]}, 8'hff);
      end
      $display("test control done");
      bus_wr(10'h3f3, 8'h03);
      bus_wr(10'h3f2, 8'h20);
      bus_wr(10'h3f2, 8'h24);
      bus_rd(10'h3f2, 8'h24, 8'hff);
      bus_rd(10'h3f3, 8'h03, 8'h03);
      for (int t = 0; t < 4; t++)
      begin
         bus_wr(10'h3f3, 8'(t));
         bus_rd(10'h3f3, 8'(t), 8'h03);
      end
      $display("test soft reset done");
      bus_wr(10'h3f2, 8'h04);
      u_fdcr_drive_model.pulse(1'b0);
      u_fdcr_drive_model.pulse(1'b1);
      write_gate_out = 1'b1;
      idle(6);
      bus_rd(10'h3f1, 8'hdc, 8'hff);
      idle(1);
      u_fdcr_drive_model.pulse(1'b0);
      idle(6);
      bus_rd(10'h3f1, 8'hd4, 8'hff);
      write_gate_out = 1'b0;
      $display("test toggles done");
      {dma_ack_bar, terminal_count} = 2'h1;
      do_reset(FDCR_MODE_AT, 1'b0);
      bus_rd(10'h3f1, 8'h00, 8'h00);
      bus_rd(10'h3f5, 8'h00, 8'h00);
      bus_wr(10'h3f2, 8'h14);
      idle(6);
      chk_pin("dma_request_oe", 1'b0, dma_request_oe);
      chk_pin("dma_ack_bar_gated", 1'b1, dma_ack_bar_gated);
      chk_pin("terminal_count_gated", 1'b0, terminal_count_gated);
      bus_wr(10'h3f2, 8'h1c);
      idle(6);
      chk_pin("floppy_irq_oe", 1'b1, floppy_irq_oe);
      chk_pin("dma_ack_bar_gated", 1'b0, dma_ack_bar_gated);
      chk_pin("terminal_count_gated", 1'b1, terminal_count_gated);
      chk_pin("dma_request", core_dma_request, dma_request);
      chk_pin("floppy_irq", core_floppy_irq, floppy_irq);
      $display("test basic mode done");
      do_reset(FDCR_MODE_LEGACY, 1'b1);
      bus_wr(10'h3f2, 8'h1c);
      idle(4);
      bus_rd(10'h3f1, 8'h23, 8'hff);
      idle(1);
      u_fdcr_drive_model.pulse(1'b0);
      u_fdcr_drive_model.pulse(1'b1);
      write_gate_out = 1'b1;
      idle(6);
      bus_rd(10'h3f1, 8'h3f, 8'hff);
      write_gate_out = 1'b0;
      op(1'b1, 1'b0, 10'h3f7, 8'h00, 1'b0);
      idle(2);
      bus_rd(10'h3f1, 8'h23, 8'hff);
      idle(3);
      $display("test legacy done");
      close_out();
   end
endmodule : fdcr_drive_ctrl_test
bind fdcr_drive_ctrl fdcr_drive_ctrl_asserts u_asserts (.clk, .rst, .cfg_mode, .cfg_swap,
   .host, .rdata, .rdata_oe, .drive_select_out_bar, .motor_on_out_bar, .dma_request_oe,
   .floppy_irq_oe, .dma_ack_bar_gated, .core_reset, .terminal_count_gated, .dma_request,
   .floppy_irq, .core_dma_request, .core_floppy_irq);
